// ==== hw/nvmcfg_consts.vh ====
`ifndef NVMCFG_CONSTS_VH
`define NVMCFG_CONSTS_VH
`define NVMCFG_IDX_LINK 8'h1B
`define NVMCFG_IDX_PHY 8'h1C
`define NVMCFG_ADDR_LINK 8'h6C
`define NVMCFG_ADDR_PHY 8'h70
`define NVMCFG_ADDR_STAT 8'h80
`define NVMCFG_ADDR_CTRL 8'h84
`define NVMCFG_LINK_RST 16'h4403
`define NVMCFG_PHY_RST 16'h0C84
`define NVMCFG_LINK_MASK 16'hFC37
`define NVMCFG_PHY_MASK 16'h5EEF
`define NVMCFG_B_RXPRES 15
`define NVMCFG_B_DLYMSB 14
`define NVMCFG_B_NORST 13
`define NVMCFG_B_LEGACY 12
`define NVMCFG_B_GOODREC 11
`define NVMCFG_B_NOLEAK 10
`define NVMCFG_B_NOL2 5
`define NVMCFG_B_NOSKIP 4
`define NVMCFG_B_IDLEMASK 2
`define NVMCFG_B_NOGIG 14
`define NVMCFG_B_CLASSA 12
`define NVMCFG_B_GIGD0A 11
`define NVMCFG_B_SLEEP_SPEED_REDUCTION_ENABLE 10
`define NVMCFG_B_D0LPLU 9
`define NVMCFG_B_BLINK 7
`define NVMCFG_B_INVERT 6
`define NVMCFG_B_RATE 5
`define NVMCFG_CLK_KHZ 40000
`define NVMCFG_T32_US 32
`define NVMCFG_T64_US 64
`define NVMCFG_T256_US 256
`define NVMCFG_T1_MS 1
`define NVMCFG_T4_MS 4
`define NVMCFG_SLOW_MS 200
`define NVMCFG_FAST_MS 83
`define NVMCFG_RESP_OKAY 2'h0
`define NVMCFG_RESP_SLVERR 2'h2
`endif

// ==== hw/nvmcfg_loader.v ====
`timescale 1ns/100ps
`include "nvmcfg_consts.vh"
module nvmcfg_loader #(
  parameter integer CYC_32US = `NVMCFG_T32_US * `NVMCFG_CLK_KHZ / 1000,
  parameter integer CYC_64US = `NVMCFG_T64_US * `NVMCFG_CLK_KHZ / 1000,
  parameter integer CYC_256US = `NVMCFG_T256_US * `NVMCFG_CLK_KHZ / 1000,
  parameter integer CYC_1MS = `NVMCFG_T1_MS * `NVMCFG_CLK_KHZ,
  parameter integer CYC_4MS = `NVMCFG_T4_MS * `NVMCFG_CLK_KHZ,
  parameter integer CYC_SLOW = `NVMCFG_SLOW_MS * `NVMCFG_CLK_KHZ,
  parameter integer CYC_FAST = `NVMCFG_FAST_MS * `NVMCFG_CLK_KHZ
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg nvm_rd_req,
  output reg [7:0] nvm_rd_addr,
  input wire nvm_rd_ack,
  input wire [15:0] nvm_rd_data,
  input wire nvm_image_valid,
  input wire link_down,
  input wire in_d0a,
  input wire power_policy_reduce,
  output reg link_training_enable,
  output reg core_reset_req,
  output reg rx_present_force,
  output reg [2:0] lowpower_entry_delay,
  output reg [31:0] l1_entry_cycles,
  output reg legacy_training_fsm_select,
  output reg good_recovery_force,
  output reg leaky_bucket_disable,
  output reg deep_sleep_entry_inhibit,
  output reg skip_insert_disable,
  output reg eidle_check_mask,
  output reg gigabit_allowed,
  output reg line_driver_class_select,
  output reg speed_reduce_req,
  output reg activity_indicator_flash_enable,
  output reg activity_indicator_polarity,
  output reg activity_indicator_flash_rate,
  output reg [31:0] flash_half_cycles,
  output reg [3:0] activity_indicator_source
);

  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_LINK = 2'b01;
  localparam [1:0] ST_PHY = 2'b10;
  localparam [1:0] ST_DONE = 2'b11;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [15:0] link_reg;
  reg [15:0] phy_reg;
  reg image_seen_reg;
  reg [7:0] awaddr_reg;
  reg aw_held_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg w_held_reg;
  reg [15:0] wr_word;
  reg [31:0] rd_word;
  reg rd_ok;
  reg [31:0] l1_next;
  wire do_write;
  wire wr_link;
  wire wr_phy;
  wire wr_ctrl;
  wire wr_hit;
  wire rd_take;

  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_link = do_write && (awaddr_reg == `NVMCFG_ADDR_LINK);
  assign wr_phy = do_write && (awaddr_reg == `NVMCFG_ADDR_PHY);
  assign wr_ctrl = do_write && (awaddr_reg == `NVMCFG_ADDR_CTRL);
  assign wr_hit = wr_link || wr_phy || wr_ctrl || (awaddr_reg == `NVMCFG_ADDR_STAT);
  assign rd_take = s_axi_arvalid && s_axi_arready;

  // Merges the byte lanes of a write into the current 16-bit word.
  always @* begin
    wr_word = wr_link ? link_reg : phy_reg;
    if (wstrb_reg[0]) begin
      wr_word[7:0] = wdata_reg[7:0];
    end
    if (wstrb_reg[1]) begin
      wr_word[15:8] = wdata_reg[15:8];
    end
  end

  // Loader sequence: link word, then PHY word, then release training.
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        state_next = nvm_image_valid ? ST_LINK : ST_DONE;
      end
      ST_LINK: begin
        if (nvm_rd_ack) begin
          state_next = ST_PHY;
        end
      end
      ST_PHY: begin
        if (nvm_rd_ack) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        if (wr_ctrl && wstrb_reg[0] && wdata_reg[0]) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      nvm_rd_req <= 1'b0;
      nvm_rd_addr <= 8'h00;
      image_seen_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      nvm_rd_req <= (state_next == ST_LINK) || (state_next == ST_PHY);
      nvm_rd_addr <= (state_next == ST_PHY) ? `NVMCFG_IDX_PHY : `NVMCFG_IDX_LINK;
      if (state_reg == ST_IDLE) begin
        image_seen_reg <= nvm_image_valid;
      end
    end
  end

  // Configuration words; reserved bits are stored and read as zero.
  always @(posedge aclk) begin
    if (!aresetn) begin
      link_reg <= `NVMCFG_LINK_RST;
      phy_reg <= `NVMCFG_PHY_RST;
    end else begin
      if (state_reg == ST_IDLE && !nvm_image_valid) begin
        link_reg <= `NVMCFG_LINK_RST;
        phy_reg <= `NVMCFG_PHY_RST;
      end else if (state_reg == ST_LINK && nvm_rd_ack) begin
        link_reg <= nvm_rd_data & `NVMCFG_LINK_MASK;
      end else if (state_reg == ST_PHY && nvm_rd_ack) begin
        phy_reg <= nvm_rd_data & `NVMCFG_PHY_MASK;
      end else if (wr_link) begin
        link_reg <= wr_word & `NVMCFG_LINK_MASK;
      end else if (wr_phy) begin
        phy_reg <= wr_word & `NVMCFG_PHY_MASK;
      end
    end
  end

  // Write address and data are taken in either order and held.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `NVMCFG_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `NVMCFG_RESP_OKAY : `NVMCFG_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
      end
    end
  end

  always @* begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `NVMCFG_ADDR_LINK: rd_word = {16'h0000, link_reg};
      `NVMCFG_ADDR_PHY: rd_word = {16'h0000, phy_reg};
      `NVMCFG_ADDR_STAT: rd_word = {29'h0, image_seen_reg,
        link_training_enable, nvm_rd_req};
      `NVMCFG_ADDR_CTRL: rd_word = 32'h0000_0000;
      default: begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `NVMCFG_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_take;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? `NVMCFG_RESP_OKAY : `NVMCFG_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // L0s-to-L1 delay from the three-bit field.
  always @* begin
    case (link_reg[1:0])
      2'b00: l1_next = CYC_64US;
      2'b01: l1_next = CYC_256US;
      2'b10: l1_next = CYC_1MS;
      default: l1_next = CYC_4MS;
    endcase
    if ({link_reg[`NVMCFG_B_DLYMSB], link_reg[1:0]} == 3'b011) begin
      l1_next = CYC_32US;
    end
  end

  // Decoded settings, registered so every output comes from a flop.
  always @(posedge aclk) begin
    if (!aresetn) begin
      link_training_enable <= 1'b0;
      core_reset_req <= 1'b0;
      rx_present_force <= 1'b0;
      lowpower_entry_delay <= 3'b111;
      l1_entry_cycles <= 32'h0000_0000;
      legacy_training_fsm_select <= 1'b0;
      good_recovery_force <= 1'b0;
      leaky_bucket_disable <= 1'b1;
      deep_sleep_entry_inhibit <= 1'b0;
      skip_insert_disable <= 1'b0;
      eidle_check_mask <= 1'b0;
      gigabit_allowed <= 1'b0;
      line_driver_class_select <= 1'b0;
      speed_reduce_req <= 1'b0;
      activity_indicator_flash_enable <= 1'b1;
      activity_indicator_polarity <= 1'b0;
      activity_indicator_flash_rate <= 1'b0;
      flash_half_cycles <= 32'h0000_0000;
      activity_indicator_source <= 4'h4;
    end else begin
      link_training_enable <= (state_reg == ST_DONE);
      core_reset_req <= link_down && !link_reg[`NVMCFG_B_NORST];
      rx_present_force <= link_reg[`NVMCFG_B_RXPRES];
      lowpower_entry_delay <= {link_reg[`NVMCFG_B_DLYMSB], link_reg[1:0]};
      l1_entry_cycles <= l1_next;
      legacy_training_fsm_select <= link_reg[`NVMCFG_B_LEGACY];
      good_recovery_force <= link_reg[`NVMCFG_B_GOODREC];
      leaky_bucket_disable <= link_reg[`NVMCFG_B_NOLEAK];
      deep_sleep_entry_inhibit <= link_reg[`NVMCFG_B_NOL2];
      skip_insert_disable <= link_reg[`NVMCFG_B_NOSKIP];
      eidle_check_mask <= link_reg[`NVMCFG_B_IDLEMASK];
      gigabit_allowed <= !phy_reg[`NVMCFG_B_NOGIG] &&
        !(phy_reg[`NVMCFG_B_GIGD0A] && !in_d0a);
      line_driver_class_select <= phy_reg[`NVMCFG_B_CLASSA];
      speed_reduce_req <= power_policy_reduce &&
        (in_d0a ? phy_reg[`NVMCFG_B_D0LPLU]
        : phy_reg[`NVMCFG_B_SLEEP_SPEED_REDUCTION_ENABLE]);
      activity_indicator_flash_enable <= phy_reg[`NVMCFG_B_BLINK];
      activity_indicator_polarity <= phy_reg[`NVMCFG_B_INVERT];
      activity_indicator_flash_rate <= phy_reg[`NVMCFG_B_RATE];
      flash_half_cycles <= phy_reg[`NVMCFG_B_RATE] ? CYC_FAST : CYC_SLOW;
      activity_indicator_source <= phy_reg[3:0];
    end
  end

endmodule

// ==== verification/nlplc_monitor.sv ====
`timescale 1ns/100ps
module nlplc_monitor #(
  parameter integer CYC_32US = 1280
) (
  input wire aclk,
  input wire aresetn,
  input wire nvm_rd_req,
  input wire [7:0] nvm_rd_addr,
  input wire nvm_rd_ack,
  input wire [15:0] nvm_rd_data,
  input wire link_down,
  input wire core_reset_req,
  input wire power_policy_reduce,
  input wire speed_reduce_req,
  input wire link_training_enable,
  input wire rx_present_force,
  input wire deep_sleep_entry_inhibit,
  input wire [2:0] lowpower_entry_delay,
  input wire [31:0] l1_entry_cycles,
  input wire [3:0] activity_indicator_source,
  input wire activity_indicator_flash_rate
);
  reg [15:0] cap_link;
  reg [15:0] cap_phy;
  // Each word is kept as it arrives so the outputs it drives can be judged.
  always @(posedge aclk) begin
    if (nvm_rd_ack && nvm_rd_addr == 8'h1b) begin
      cap_link <= nvm_rd_data;
    end
    if (nvm_rd_ack && nvm_rd_addr == 8'h1c) begin
      cap_phy <= nvm_rd_data;
    end
  end
  default clocking mon_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_req_held: assert property
    (nvm_rd_req && !nvm_rd_ack |=> nvm_rd_req && $stable(nvm_rd_addr))
    else $error("word request changed before its ack");
  a_load_order: assert property
    (nvm_rd_req && nvm_rd_ack && nvm_rd_addr == 8'h1b |=> nvm_rd_req && nvm_rd_addr == 8'h1c)
    else $error("second word not requested after the first");
  a_train_after: assert property ($rose(link_training_enable) |-> !nvm_rd_req)
    else $error("training enabled while loading");
  a_core_reset: assert property (core_reset_req |-> $past(link_down))
    else $error("core reset without link down");
  a_speed_cause: assert property (speed_reduce_req |-> $past(power_policy_reduce))
    else $error("speed reduction without policy request");
  a_l1_short: assert property
    ((lowpower_entry_delay == 3'b011) [*3] |-> l1_entry_cycles == CYC_32US)
    else $error("short entry delay count wrong");
  a_link_loaded: assert property (nvm_rd_ack && nvm_rd_addr == 8'h1b |=> ##[0:1]
    (rx_present_force == cap_link[15] && deep_sleep_entry_inhibit == cap_link[5]))
    else $error("link word not applied");
  a_phy_loaded: assert property (nvm_rd_ack && nvm_rd_addr == 8'h1c |=> ##[0:1]
    (activity_indicator_source == cap_phy[3:0] && activity_indicator_flash_rate == cap_phy[5]))
    else $error("phy word not applied");
endmodule
bind nvmcfg_loader nlplc_monitor #(.CYC_32US(CYC_32US)) u_mon (.*);

// ==== verification/nlplc_nvm_model.sv ====
`timescale 1ns/100ps
module nlplc_nvm_model (
  input wire aclk,
  input wire aresetn,
  input wire nvm_rd_req,
  input wire [7:0] nvm_rd_addr,
  output logic nvm_rd_ack = 1'b0,
  output logic [15:0] nvm_rd_data = 16'h0000,
  input wire [15:0] img_link,
  input wire [15:0] img_phy,
  input wire [3:0] nvm_wait
);
  logic [3:0] cnt;
  // Answers the first word nvm_wait+1 cycles after the request and the second nvm_wait+2 after the first ack; data is garbled outside the ack.
  always @(posedge aclk) begin
    nvm_rd_ack <= 1'b0;
    if (nvm_rd_ack) begin
      nvm_rd_data <= ~nvm_rd_data;
    end
    if (!aresetn || !nvm_rd_req || nvm_rd_ack) begin
      cnt <= 4'h0;
    end else if (cnt == nvm_wait) begin
      nvm_rd_ack <= 1'b1;
      nvm_rd_data <= (nvm_rd_addr == 8'h1c) ? img_phy : img_link;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

// ==== verification/nvm_link_phy_led_config_tb_top.sv ====
`timescale 1ns/100ps
module nvm_link_phy_led_config_tb_top;
  localparam int C32 = 2, C64 = 3, C256 = 5, C1M = 7, C4M = 11, CS = 13, CF = 17;
  localparam logic [15:0] LW [5] = '{16'h0000, 16'h5555, 16'haaaa, 16'hffff, 16'h0003};
  localparam logic [15:0] PW [5] = '{16'h0000, 16'h5555, 16'haaaa, 16'hffff, 16'h0c84};
  logic aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '1;
  logic s_axi_arvalid = '0, s_axi_rready = '1, nvm_image_valid = '0, link_down = '0;
  logic in_d0a = '0, power_policy_reduce = '0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, nvm_rd_req, nvm_rd_ack, link_training_enable;
  logic core_reset_req, rx_present_force, legacy_training_fsm_select, good_recovery_force;
  logic leaky_bucket_disable, deep_sleep_entry_inhibit, skip_insert_disable, eidle_check_mask;
  logic gigabit_allowed, line_driver_class_select, speed_reduce_req;
  logic activity_indicator_flash_enable, activity_indicator_polarity;
  logic activity_indicator_flash_rate;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, nvm_rd_addr;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, l1_entry_cycles, flash_half_cycles;
  logic [3:0] s_axi_wstrb = 4'h3, nvm_wait = '0, activity_indicator_source;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0] lowpower_entry_delay;
  logic [15:0] nvm_rd_data, img_link = '0, img_phy = '0;
  int n_fail = 0, n_tests = 0;
  nvmcfg_loader #(.CYC_32US(C32), .CYC_64US(C64), .CYC_256US(C256), .CYC_1MS(C1M),
    .CYC_4MS(C4M), .CYC_SLOW(CS), .CYC_FAST(CF)) u_dut (.*);
  nlplc_nvm_model u_nvm (.*);
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask
  task automatic check_reg(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    check_val(s_axi_rdata, e);
    check_val(s_axi_rresp, er);
  endtask
  function automatic logic [31:0] l1_exp(input logic [15:0] w);
    if ({w[14], w[1:0]} == 3'b011) return C32;
    return w[1] ? (w[0] ? C4M : C1M) : (w[0] ? C256 : C64);
  endfunction
  task automatic check_link(input logic [15:0] w);
    check_val({rx_present_force, lowpower_entry_delay, legacy_training_fsm_select,
      good_recovery_force, leaky_bucket_disable, deep_sleep_entry_inhibit,
      skip_insert_disable, eidle_check_mask, core_reset_req},
      {w[15:14], w[1:0], w[12:10], w[5:4], w[2], link_down & ~w[13]});
    check_val(l1_entry_cycles, l1_exp(w));
  endtask
  task automatic check_phy(input logic [15:0] w);
    for (int k = 0; k < 4; k++) begin
      {in_d0a, power_policy_reduce} <= k[1:0];
      repeat (3) @(posedge aclk);
      check_val({gigabit_allowed, speed_reduce_req}, {~w[14] & ~(w[11] & ~in_d0a),
        power_policy_reduce & (in_d0a ? w[9] : w[10])});
    end
    check_val({line_driver_class_select, activity_indicator_flash_enable,
      activity_indicator_polarity, activity_indicator_flash_rate, activity_indicator_source},
      {w[12], w[7:5], w[3:0]});
    check_val(flash_half_cycles, w[5] ? CF : CS);
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    // With no valid image every field takes its default.
    check_link(16'h4403);
    check_phy(16'h0c84);
    check_reg(8'h80, 32'h0000_0002, 2'h0);
    for (int i = 0; i < 5; i++) begin
      link_down <= i[0];
      axi_wr(8'h6c, {16'hffff, LW[i]}, rsp);
      check_val(rsp, 2'h0);
      axi_wr(8'h70, {16'hffff, PW[i]}, rsp);
      check_val(rsp, 2'h0);
      repeat (3) @(posedge aclk);
      check_link(LW[i]);
      check_phy(PW[i]);
      check_reg(8'h6c, {16'h0000, LW[i] & 16'hfc37}, 2'h0);
      check_reg(8'h70, {16'h0000, PW[i] & 16'h5eef}, 2'h0);
    end
    axi_wr(8'h40, 32'h0000_0001, rsp);
    check_val(rsp, 2'h2);
    check_reg(8'h40, 32'h0000_0000, 2'h2);
    nvm_image_valid <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      img_link <= i ? 16'h8a31 : 16'h3c06;
      img_phy <= i ? 16'h4a2b : 16'h1371;
      nvm_wait <= i ? 4'h9 : 4'h0;
      axi_wr(8'h84, 32'h0000_0001, rsp);
      check_val(rsp, 2'h0);
      repeat (2) begin
        do @(posedge aclk); while (nvm_rd_ack !== 1'b1);
      end
      repeat (4) @(posedge aclk);
      check_link(img_link);
      check_phy(img_phy);
      check_reg(8'h80, 32'h0000_0006, 2'h0);
    end
    tally_and_finish;
  end
  initial begin
    #(25 * 20000);
    n_fail++;
    tally_and_finish;
  end
endmodule
